/* include/usart_irq_pkg.sv */
/*
  Shared constants for the serial port interrupt and status register bank:
  register byte offsets, flag bit positions, reset values.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package usart_irq_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ENABLE_VIEW = 8'h10;
  localparam logic [7:0] OFS_CHANNEL_FLAGS = 8'h14;
  localparam logic [7:0] OFS_RX_HOLDING_REG = 8'h18;
  localparam logic [7:0] OFS_STATUS_CMD = 8'h00;
  // ==========================================================================
  // flag bit positions
  localparam int BIT_RX_CHAR_AVAIL = 0;
  localparam int BIT_TX_HOLD_FREE = 1;
  localparam int BIT_BREAK_SEEN = 2;
  localparam int BIT_RX_DMA_DONE = 3;
  localparam int BIT_TX_DMA_DONE = 4;
  localparam int BIT_OVERRUN_ERR = 5;
  localparam int BIT_FRAMING_ERR = 6;
  localparam int BIT_PARITY_ERR = 7;
  localparam int BIT_RX_TIMEOUT = 8;
  localparam int BIT_TX_ALL_DRAINED = 9;
  localparam int BIT_ITER_LIMIT = 10;
  localparam int BIT_TX_DMA_BUF_EMPTY = 11;
  localparam int BIT_RX_DMA_BUF_FULL = 12;
  localparam int BIT_NACK_SEEN = 13;
  localparam int BIT_LINE_CHANGED_LO = 16;
  localparam int BIT_LINE_LEVEL_LO = 20;
  localparam int NUM_LINES = 4;
  // status command bit: clears the sticky receive errors
  localparam int BIT_CMD_RESET_STATUS = 8;
  // ==========================================================================
  // implemented bits of the enable / mask layout
  localparam logic [31:0] IRQ_FULL_MASK = 32'h000F_3FFF;
  localparam logic [31:0] IRQ_REDUCED_MASK = 32'h0008_3FFF;
  localparam logic [31:0] IRQ_ENABLE_RESET = 32'h0000_0000;
  localparam logic [3:0] LINE_CHANGED_RESET = 4'h0;
  // edges after reset before a line's level register holds a real pin value
  localparam logic [1:0] LINE_SETTLE_CYCLES = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : usart_irq_pkg

/* design/line_change_detect.sv */
/*
  One modem input line: two-flop synchroniser, edge detect, sticky change
  flag cleared by a read strobe, and the synchronised level.
  Assumes the line is asynchronous to sys_clk.
*/
`timescale 1ns/1ns
module line_change_detect
  import usart_irq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic line_in,
  input wire logic present,
  input wire logic read_clear,
  output logic changed,
  output logic level
);
  logic sync_a;
  logic sync_b;
  logic change_now;
  logic [1:0] settle;
  logic settled;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      level <= 1'b0;
    end else if (clk_en) begin
      sync_a <= line_in;
      sync_b <= sync_a;
      level <= sync_b; // R14
    end
  end

  // a pin already high at reset must not look like an edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      settle <= 2'h0;
    end else if (clk_en && settle != LINE_SETTLE_CYCLES) begin
      settle <= settle + 2'h1;
    end
  end

  assign settled = (settle == LINE_SETTLE_CYCLES);
  assign change_now = present && settled && (sync_b != level);

  // set wins over a simultaneous read clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      changed <= 1'b0;
    end else if (clk_en) begin
      if (change_now) begin
        changed <= 1'b1; // R12
      end else if (read_clear) begin
        changed <= 1'b0; // R12
      end
    end
  end

  a_change_sets_flag: assert property (@(posedge sys_clk) disable iff (reset) // R12
    clk_en && change_now |=> changed)
    else $error("line change did not set its flag");
endmodule : line_change_detect

/* design/usart_irq_status_regs.sv */
/*
  Interrupt enable/disable/mask registers and channel status register of a
  serial port, reached over AXI4-Lite, with one level interrupt output.
  Assumes the serial engine and DMA channels supply event flags on sys_clk
  and that modem lines are asynchronous pins.
*/
// Summary of operation
// R1: writing a one to a bit of irq_enable_set enables that event's interrupt.
// R2: writing a one to a bit of irq_enable_clear disables that event's interrupt.
// R3: irq_enable_view reads back which interrupts are enabled, same layout.
// R4: bits 0..7 are rx ready, tx ready, break, rx dma end, tx dma end, overrun, framing, parity.
// R5: bits 8..13 are timeout, tx empty, iteration, tx buf empty, rx buf full, nack; 14,15,24..31 reserved.
// R6: bits 16..19 are change flags for ring, set ready, carrier and clear to send.
// R7: in a reduced variant the ring, set ready and carrier change bits do nothing.
// R8: channel_flags holds the event flags plus line levels at bits 20..23.
// R9: rx ready reads 0 when the receiver is off or nothing new has arrived.
// R10: a character received while disabled shows as rx ready once re-enabled.
// R11: rx ready reads 1 while a complete character waits unread.
// R12: a line change flag is set by any change and cleared by reading channel_flags.
// R13: overrun, framing and parity errors stay set until the reset-status command.
// R14: a line level bit reads 1 while the line is high.
// R15: the interrupt is high while a flag with its mask bit set is set; writing 0 does nothing.
`timescale 1ns/1ns
module usart_irq_status_regs
  import usart_irq_pkg::*;
#(
  parameter bit FULL_MODEM = 1'b1
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_enabled,
  input wire logic rx_char_strobe,
  input wire logic [8:0] rx_char_data,
  input wire logic tx_hold_free,
  input wire logic break_seen,
  input wire logic rx_dma_done,
  input wire logic tx_dma_done,
  input wire logic overrun_err,
  input wire logic framing_err,
  input wire logic parity_err,
  input wire logic rx_timeout,
  input wire logic tx_all_drained,
  input wire logic iter_limit,
  input wire logic tx_dma_buf_empty,
  input wire logic rx_dma_buf_full,
  input wire logic nack_seen,
  input wire logic ring_line,
  input wire logic set_ready_line,
  input wire logic carrier_line,
  input wire logic clear_send_line,
  output logic port_irq
);
  // ==========================================================================
  // state
  localparam logic [31:0] IMPL_MASK = FULL_MODEM ? IRQ_FULL_MASK : IRQ_REDUCED_MASK;
  logic [31:0] irq_enable;
  logic [2:0] err_sticky;
  logic rx_pending;
  logic [8:0] rx_holding_reg;
  logic [3:0] line_changed;
  logic [3:0] line_level;
  logic [3:0] line_in;
  logic [3:0] line_present;
  logic [31:0] flags;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic wr_ok;
  logic rd_ok;
  logic status_read;
  logic rhr_read;
  logic [31:0] next_rdata;
  logic [31:0] wr_bits;

  // ==========================================================================
  // AXI4-Lite write path
  assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = clk_en && !w_held && !s_axi_bvalid;
  assign do_write = clk_en && aw_held && w_held && !s_axi_bvalid;
  assign wr_bits = w_data & {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wr_ok = (aw_addr == OFS_IRQ_ENABLE_SET) || (aw_addr == OFS_IRQ_ENABLE_CLEAR)
    || (aw_addr == OFS_STATUS_CMD);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // interrupt enable bank: set/clear by ones only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_enable <= IRQ_ENABLE_RESET;
    end else if (do_write) begin
      if (aw_addr == OFS_IRQ_ENABLE_SET) begin
        irq_enable <= irq_enable | (wr_bits & IMPL_MASK); // R1 R7 R15
      end else if (aw_addr == OFS_IRQ_ENABLE_CLEAR) begin
        irq_enable <= irq_enable & ~(wr_bits & IMPL_MASK); // R2 R15
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  assign do_read = clk_en && s_axi_arvalid && s_axi_arready;
  assign status_read = do_read && (s_axi_araddr == OFS_CHANNEL_FLAGS);
  assign rhr_read = do_read && (s_axi_araddr == OFS_RX_HOLDING_REG);
  assign rd_ok = (s_axi_araddr == OFS_IRQ_ENABLE_VIEW) || (s_axi_araddr == OFS_CHANNEL_FLAGS)
    || (s_axi_araddr == OFS_RX_HOLDING_REG);

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (s_axi_araddr)
      OFS_IRQ_ENABLE_VIEW: next_rdata = irq_enable; // R3
      OFS_CHANNEL_FLAGS: next_rdata = flags; // R8
      OFS_RX_HOLDING_REG: next_rdata = {23'h000000, rx_holding_reg};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // receive character pending and holding register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_pending <= 1'b0;
      rx_holding_reg <= 9'h000;
    end else if (clk_en) begin
      if (rx_char_strobe) begin
        rx_pending <= 1'b1; // R11 R10
        rx_holding_reg <= rx_char_data;
      end else if (rhr_read) begin
        rx_pending <= 1'b0; // R9
      end
    end
  end

  // ==========================================================================
  // sticky receive errors, cleared by the reset-status command
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      err_sticky <= 3'h0;
    end else if (clk_en) begin
      if (do_write && aw_addr == OFS_STATUS_CMD && wr_bits[BIT_CMD_RESET_STATUS]) begin
        err_sticky <= {parity_err, framing_err, overrun_err}; // R13
      end else begin
        err_sticky <= err_sticky | {parity_err, framing_err, overrun_err}; // R13
      end
    end
  end

  // ==========================================================================
  // modem lines: ring, set ready, carrier, clear to send
  assign line_in = {clear_send_line, carrier_line, set_ready_line, ring_line};
  assign line_present = {1'b1, {3{FULL_MODEM}}}; // R7

  genvar li;
  generate
    for (li = 0; li < NUM_LINES; li++) begin : g_line
      line_change_detect u_line (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .line_in(line_in[li]),
        .present(line_present[li]),
        .read_clear(status_read),
        .changed(line_changed[li]),
        .level(line_level[li])
      );
    end
  endgenerate

  // ==========================================================================
  // status word and interrupt
  always_comb begin
    flags = 32'h0000_0000;
    flags[BIT_RX_CHAR_AVAIL] = rx_pending && rx_enabled; // R9 R10 R11
    flags[BIT_TX_HOLD_FREE] = tx_hold_free; // R4
    flags[BIT_BREAK_SEEN] = break_seen;
    flags[BIT_RX_DMA_DONE] = rx_dma_done;
    flags[BIT_TX_DMA_DONE] = tx_dma_done;
    flags[BIT_OVERRUN_ERR] = err_sticky[0];
    flags[BIT_FRAMING_ERR] = err_sticky[1];
    flags[BIT_PARITY_ERR] = err_sticky[2];
    flags[BIT_RX_TIMEOUT] = rx_timeout; // R5
    flags[BIT_TX_ALL_DRAINED] = tx_all_drained;
    flags[BIT_ITER_LIMIT] = iter_limit;
    flags[BIT_TX_DMA_BUF_EMPTY] = tx_dma_buf_empty;
    flags[BIT_RX_DMA_BUF_FULL] = rx_dma_buf_full;
    flags[BIT_NACK_SEEN] = nack_seen;
    flags[BIT_LINE_CHANGED_LO +: NUM_LINES] = line_changed; // R6
    flags[BIT_LINE_LEVEL_LO +: NUM_LINES] = line_level; // R14
  end

  assign port_irq = |(flags & irq_enable & IMPL_MASK); // R15

  // ==========================================================================
  // checks
  a_enable_set_bit: assert property (@(posedge sys_clk) disable iff (reset) // R1
    do_write && aw_addr == OFS_IRQ_ENABLE_SET && (wr_bits & IMPL_MASK) != 32'h0
    |=> (irq_enable & $past(wr_bits & IMPL_MASK)) == $past(wr_bits & IMPL_MASK))
    else $error("enable write did not set mask bits");
  a_disable_clear_bit: assert property (@(posedge sys_clk) disable iff (reset) // R2
    do_write && aw_addr == OFS_IRQ_ENABLE_CLEAR
    |=> (irq_enable & $past(wr_bits & IMPL_MASK)) == 32'h0)
    else $error("disable write did not clear mask bits");
  a_zero_no_effect: assert property (@(posedge sys_clk) disable iff (reset) // R15
    !(do_write && (aw_addr == OFS_IRQ_ENABLE_SET || aw_addr == OFS_IRQ_ENABLE_CLEAR)
    && (wr_bits & IMPL_MASK) != 32'h0000_0000) |=> $stable(irq_enable))
    else $error("mask changed without a write");
  a_view_reads_mask: assert property (@(posedge sys_clk) disable iff (reset) // R3
    do_read && s_axi_araddr == OFS_IRQ_ENABLE_VIEW && !do_write |=> s_axi_rdata == irq_enable)
    else $error("mask view read wrong");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (reset) // R5
    (irq_enable & ~IMPL_MASK) == 32'h0 && flags[15:14] == 2'b00 && flags[31:24] == 8'h00)
    else $error("reserved bit set");
  a_rx_ready_off: assert property (@(posedge sys_clk) disable iff (reset) // R9
    !rx_enabled |-> !flags[BIT_RX_CHAR_AVAIL])
    else $error("rx ready while receiver off");
  a_rx_ready_hold: assert property (@(posedge sys_clk) disable iff (reset) // R11
    clk_en && rx_char_strobe ##1 (rx_enabled && !rhr_read)[*2] |-> flags[BIT_RX_CHAR_AVAIL])
    else $error("rx ready lost before read");
  a_error_sticky: assert property (@(posedge sys_clk) disable iff (reset) // R13
    clk_en && overrun_err |=> flags[BIT_OVERRUN_ERR])
    else $error("overrun flag not sticky");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (reset) // R15
    (irq_enable[BIT_PARITY_ERR] && flags[BIT_PARITY_ERR]) |-> port_irq)
    else $error("unmasked flag did not raise interrupt");
  a_reduced_quiet: assert property (@(posedge sys_clk) disable iff (reset) // R7
    !FULL_MODEM |-> flags[BIT_LINE_CHANGED_LO +: 3] == 3'b000)
    else $error("absent line change flag set");

  // ==========================================================================
  // bus handshake and freeze checks
  a_bvalid_stands: assert property (@(posedge sys_clk) disable iff (reset)
    s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rvalid_stands: assert property (@(posedge sys_clk) disable iff (reset)
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped before taken");
  a_unmapped_slverr: assert property (@(posedge sys_clk) disable iff (reset)
    do_read && !rd_ok
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_write_resp_code: assert property (@(posedge sys_clk) disable iff (reset)
    do_write && !wr_ok
    |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_freeze_state: assert property (@(posedge sys_clk) disable iff (reset)
    !clk_en
    |=> $stable(irq_enable) && $stable(err_sticky) && $stable(rx_pending))
    else $error("state moved while clock enable low");
  a_status_rdata: assert property (@(posedge sys_clk) disable iff (reset) // R8
    do_read && s_axi_araddr == OFS_CHANNEL_FLAGS
    |=> s_axi_rdata == $past(flags))
    else $error("status read returned wrong word");

  // ==========================================================================
  // receive, error and interrupt checks
  a_rx_char_pends: assert property (@(posedge sys_clk) disable iff (reset) // R11
    clk_en && rx_char_strobe
    |=> rx_pending && rx_holding_reg == $past(rx_char_data))
    else $error("received character not held");
  a_rx_read_clears: assert property (@(posedge sys_clk) disable iff (reset) // R9
    clk_en && rhr_read && !rx_char_strobe
    |=> !flags[BIT_RX_CHAR_AVAIL])
    else $error("rx ready stayed after holding read");
  a_rx_reenable_shows: assert property (@(posedge sys_clk) disable iff (reset) // R10
    rx_pending && rx_enabled
    |-> flags[BIT_RX_CHAR_AVAIL])
    else $error("pending character hidden while enabled");
  a_error_cleared: assert property (@(posedge sys_clk) disable iff (reset) // R13
    do_write && aw_addr == OFS_STATUS_CMD && wr_bits[BIT_CMD_RESET_STATUS] && !overrun_err
    |=> !flags[BIT_OVERRUN_ERR])
    else $error("reset-status did not clear overrun");
  a_irq_all_masked: assert property (@(posedge sys_clk) disable iff (reset) // R15
    irq_enable == 32'h0000_0000
    |-> !port_irq)
    else $error("interrupt high with every source masked");
endmodule : usart_irq_status_regs

/* testbench/usart_irq_status_regs_tb.sv */
/*
  Self-checking bench for the serial port interrupt/status register bank.
  Assumes the AXI4-Lite map and latencies of usart_irq_pkg and a 100 MHz sys_clk.
*/
`timescale 1ns/1ns
module usart_irq_status_regs_tb;
  import usart_irq_pkg::*;
  logic sys_clk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, port_irq, rx_en, strobe;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, tmp;
  logic [3:0] wstrb, pins, m_chg;
  logic [1:0] bresp, rresp;
  logic [8:0] cdata;
  logic [9:0] lv;
  logic [2:0] errs, m_err;
  logic [31:0] m_mask;
  logic m_rx, cke, irq_rm;
  logic [31:0] rdata_rm;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  integer seed = 32'h20D36D41;
  integer fail_count = 0;
  integer n_checks = 0;
  integer k;
  usart_irq_status_regs #(.FULL_MODEM(1'b1)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .clk_en(cke),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_enabled(rx_en), .rx_char_strobe(strobe), .rx_char_data(cdata),
    .tx_hold_free(lv[0]), .break_seen(lv[1]), .rx_dma_done(lv[2]), .tx_dma_done(lv[3]),
    .overrun_err(errs[0]), .framing_err(errs[1]), .parity_err(errs[2]),
    .rx_timeout(lv[4]), .tx_all_drained(lv[5]), .iter_limit(lv[6]),
    .tx_dma_buf_empty(lv[7]), .rx_dma_buf_full(lv[8]), .nack_seen(lv[9]),
    .ring_line(pins[0]), .set_ready_line(pins[1]), .carrier_line(pins[2]),
    .clear_send_line(pins[3]), .port_irq(port_irq)
  );
  // reduced variant on the same stimulus; bus timing is identical
  usart_irq_status_regs #(.FULL_MODEM(1'b0)) u_dut_reduced (
    .sys_clk(sys_clk), .reset(reset), .clk_en(cke),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(rdata_rm), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
    .rx_enabled(rx_en), .rx_char_strobe(strobe), .rx_char_data(cdata),
    .tx_hold_free(lv[0]), .break_seen(lv[1]), .rx_dma_done(lv[2]), .tx_dma_done(lv[3]),
    .overrun_err(errs[0]), .framing_err(errs[1]), .parity_err(errs[2]),
    .rx_timeout(lv[4]), .tx_all_drained(lv[5]), .iter_limit(lv[6]),
    .tx_dma_buf_empty(lv[7]), .rx_dma_buf_full(lv[8]), .nack_seen(lv[9]),
    .ring_line(pins[0]), .set_ready_line(pins[1]), .carrier_line(pins[2]),
    .clear_send_line(pins[3]), .port_irq(irq_rm)
  );
  // ==========================================================================
  // clock, checking and closing
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] flags_exp();
    logic [31:0] f;
    f = 32'h0000_0000;
    f[0] = m_rx;
    f[4:1] = lv[3:0];
    f[7:5] = m_err;
    f[13:8] = lv[9:4];
    f[19:16] = m_chg;
    f[23:20] = pins;
    return f;
  endfunction : flags_exp
  // watcher takes the oldest note whenever a response is handed over
  always @(posedge sys_clk) begin
    if (bvalid && bready) begin
      check({32'h0, bresp}, {32'h0, bq.pop_front()});
    end
    if (rvalid && rready) begin
      check({rresp, rdata}, rq.pop_front());
      check({31'h0, rdata_rm[18:16]}, 34'h0);
    end
  end
  // ==========================================================================
  // bus master tasks
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    integer i;
    logic ha, hw, hb;
    bq.push_back(r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(negedge sys_clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      @(posedge sys_clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        return;
      end
    end
    fail_count++;
    complete_run();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    integer i;
    logic ha, hr;
    rq.push_back({r, v});
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(negedge sys_clk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      @(posedge sys_clk);
      if (ha) arvalid <= 1'b0;
      if (hr) begin
        rready <= 1'b0;
        return;
      end
    end
    fail_count++;
    complete_run();
  endtask : axi_rd
  task automatic rd_flags();
    axi_rd(OFS_CHANNEL_FLAGS, flags_exp(), RESP_OKAY);
    m_chg = 4'h0;
  endtask : rd_flags
  task automatic chk_irq();
    @(negedge sys_clk);
    check({33'h0, port_irq}, {33'h0, |(flags_exp() & m_mask)});
    check({33'h0, irq_rm}, {33'h0, |(flags_exp() & m_mask & IRQ_REDUCED_MASK)});
  endtask : chk_irq
  // ==========================================================================
  // main sequence
  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, rx_en, strobe} = 7'h00;
    cke = 1'b1;
    {awaddr, araddr, wdata, wstrb, cdata} = '0;
    {lv, errs, pins, m_chg, m_err, m_rx} = '0;
    m_mask = IRQ_ENABLE_RESET;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    axi_rd(OFS_IRQ_ENABLE_VIEW, 32'h0, RESP_OKAY);
    rd_flags();
    for (k = 0; k < 4; k++) begin
      tmp = $random(seed);
      @(posedge sys_clk);
      lv <= tmp[9:0];
      d = $random(seed);
      axi_wr(OFS_IRQ_ENABLE_SET, d, RESP_OKAY);
      m_mask = (m_mask | d) & IRQ_FULL_MASK;
      axi_rd(OFS_IRQ_ENABLE_VIEW, m_mask, RESP_OKAY);
      chk_irq();
      d = $random(seed);
      axi_wr(OFS_IRQ_ENABLE_CLEAR, d, RESP_OKAY);
      m_mask = m_mask & ~d;
      axi_wr(OFS_IRQ_ENABLE_SET, 32'h0, RESP_OKAY);
      axi_wr(OFS_IRQ_ENABLE_CLEAR, 32'h0, RESP_OKAY);
      axi_rd(OFS_IRQ_ENABLE_VIEW, m_mask, RESP_OKAY);
      rd_flags();
      chk_irq();
    end
    @(posedge sys_clk);
    lv <= 10'h000;
    axi_wr(OFS_IRQ_ENABLE_SET, 32'hFFFF_FFFF, RESP_OKAY);
    m_mask = IRQ_FULL_MASK;
    for (k = 0; k < 3; k++) begin
      tmp = $random(seed);
      @(posedge sys_clk);
      pins <= pins ^ tmp[3:0];
      m_chg = m_chg | tmp[3:0];
      repeat (5) @(posedge sys_clk);
      chk_irq();
      rd_flags();
      rd_flags();
      chk_irq();
    end
    tmp = $random(seed);
    @(posedge sys_clk);
    errs <= tmp[2:0] | 3'h1;
    @(posedge sys_clk);
    errs <= 3'h0;
    m_err = tmp[2:0] | 3'h1;
    repeat (3) @(posedge sys_clk);
    rd_flags();
    rd_flags();
    chk_irq();
    axi_wr(OFS_STATUS_CMD, 32'h0000_0100, RESP_OKAY);
    m_err = 3'h0;
    rd_flags();
    chk_irq();
    axi_wr(OFS_IRQ_ENABLE_CLEAR, 32'hFFFF_FFFF, RESP_OKAY);
    m_mask = 32'h0;
    tmp = $random(seed);
    @(posedge sys_clk);
    rx_en <= 1'b1;
    strobe <= 1'b1;
    cdata <= tmp[8:0];
    @(posedge sys_clk);
    strobe <= 1'b0;
    m_rx = 1'b1;
    repeat (2) @(posedge sys_clk);
    rd_flags();
    axi_rd(OFS_RX_HOLDING_REG, {23'h0, cdata}, RESP_OKAY);
    m_rx = 1'b0;
    rd_flags();
    @(posedge sys_clk);
    rx_en <= 1'b0;
    strobe <= 1'b1;
    @(posedge sys_clk);
    strobe <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd_flags();
    @(posedge sys_clk);
    rx_en <= 1'b1;
    repeat (2) @(posedge sys_clk);
    m_rx = 1'b1;
    rd_flags();
    @(posedge sys_clk);
    cke <= 1'b0;
    errs <= 3'h7;
    @(posedge sys_clk);
    errs <= 3'h0;
    @(posedge sys_clk);
    cke <= 1'b1;
    rd_flags();
    axi_rd(8'h20, 32'h0, RESP_SLVERR);
    axi_rd(OFS_IRQ_ENABLE_SET, 32'h0, RESP_SLVERR);
    axi_wr(8'h40, 32'h0, RESP_SLVERR);
    repeat (5) @(posedge sys_clk);
    complete_run();
  end
endmodule : usart_irq_status_regs_tb
